// ==== qspif_host.sv ====
// Host controller model driving select, clock and data lines.
// Assumes the bench resolves each line from all drivers.
module qspif_host
(
  output logic       cs_n,
  output logic       sck,
  output logic [3:0] h_o,
  output logic [3:0] h_oe,
  input  wire  [3:0] io
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    h_o = 4'hc;
    h_oe = 4'hc;
  end

  // Set line levels and drives
  task automatic lines(input logic [3:0] v, input logic [3:0] e);
    h_o = v;
    h_oe = e;
  endtask : lines

  task automatic sel(input logic idle);
    sck = idle;
    #100 cs_n = 1'b0;
    #100 sck = 1'b0;
  endtask : sel

  task automatic unsel();
    #100 cs_n = 1'b1;
    lines(4'hc, 4'hc);
    #300;
  endtask : unsel

  task automatic put(input int lanes, input int n, input logic [7:0] d);
    h_oe = lanes == 1 ? 4'hd : 4'hf;
    for (int s = 0; s < n; s++)
    begin
      if (lanes == 4)
        h_o = d[7:4];
      else
        h_o[1:0] = 2'(d[7:4] >> (4 - lanes));
      d = d << lanes;
      #100 sck = 1'b1;
      #100 sck = 1'b0;
    end
  endtask : put

  task automatic get(input int lanes, output logic [7:0] q);
    h_oe = lanes == 4 ? 4'h0 : 4'hc;
    q = 8'h00;
    for (int s = 0; s <= 8 / lanes; s++)
    begin
      #100 sck = 1'b1;
      #100;
      if (s > 0)
        q = lanes == 4 ? {q[3:0], io} :
            lanes == 2 ? {q[5:0], io[1:0]} : {q[6:0], io[1]};
      sck = 1'b0;
    end
  endtask : get
endmodule : qspif_host

// ==== qspif_pin_if.sv ====
// Device-side pin interface of a quad serial NAND flash: select,
// serial clock edges, one/two/four lane shifting, pause and write
// protection. Assumes a command decoder on the same clock supplies
// the lane mode and drive direction and consumes received bytes.
//
// Overview of operation
// - Deselected means every data line floats.
// - No command until a select falling edge.
// - Single mode samples input line on rise.
// - Single mode drives output line on fall.
// - Multi-lane: capture on rise, drive on fall.
// - Quad uses four lanes, dual two, single one.
// - Protect-enable 0: pin guards protection register only while the SRP hardware bit is set.
// - Protect-enable 1, pin low: reject all writes.
// - Protect-enable 1 refuses quad operations.
// - Protected region none for field 0, else four blocks to whole array.
// - Pause floats output, ignores input and clock.
// - Resume continues from held state.
// - Quad command turns pause pin into data.
// - Pause follows its pin only while clock low; deselect clears it at any clock level.
// - Clock modes 0 and 3 both accepted.
module qspif_pin_if
  import qspif_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        cs_n_pin,
  input  wire logic        sck_pin,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe,
  input  wire qspif_lane_e lane_mode,
  input  wire logic        drive_out,
  input  wire logic [7:0]  tx_data,
  output logic             tx_taken,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  input  wire logic        protect_enable,
  input  wire logic [3:0]  block_protect_field,
  input  wire logic [1:0]  status_protect_field,
  output logic             selected,
  output logic             armed,
  output logic             paused,
  output logic             mode3,
  output logic             quad_refused,
  output logic             array_write_ok,
  output logic             protreg_write_ok,
  output logic [11:0]      protect_blocks
);

  // -------------------------------------------------------------------
  // Lane helpers
  // -------------------------------------------------------------------

  // Bits moved per clock edge
  function automatic logic [2:0] lane_step(qspif_lane_e m);
    case (m)
      QSPIF_DUAL: lane_step = 3'h2;
      QSPIF_QUAD: lane_step = 3'h4;
      default:    lane_step = 3'h1;
    endcase
  endfunction : lane_step

  // Lines driven in a read phase
  function automatic logic [3:0] lane_oe(qspif_lane_e m);
    case (m)
      QSPIF_DUAL: lane_oe = 4'h3;
      QSPIF_QUAD: lane_oe = 4'hf;
      default:    lane_oe = 4'h2;
    endcase
  endfunction : lane_oe

  // Shift captured lanes in, MSB first
  function automatic logic [7:0] shift_in(logic [7:0] sh,
                                          logic [3:0] io,
                                          qspif_lane_e m);
    case (m)
      QSPIF_DUAL: shift_in = {sh[5:0], io[1:0]};
      QSPIF_QUAD: shift_in = {sh[3:0], io[3:0]};
      default:    shift_in = {sh[6:0], io[QSPIF_IO0]};
    endcase
  endfunction : shift_in

  // Place the top bits of a byte on the lanes
  function automatic logic [3:0] lane_out(logic [7:0] b, qspif_lane_e m);
    case (m)
      QSPIF_DUAL: lane_out = {2'h0, b[7:6]};
      QSPIF_QUAD: lane_out = b[7:4];
      default:    lane_out = {2'h0, b[7], 1'h0};
    endcase
  endfunction : lane_out

  // Blocks covered by the protect field, doubling from the minimum
  function automatic logic [11:0] region_blocks(logic [3:0] bp);
    int n;
    n = 0;
    if (bp != 4'h0)
    begin
      n = QSPIF_MIN_PROT_BLKS << (int'(bp) - 1);
      if (n > QSPIF_ARRAY_BLKS)
      begin
        n = QSPIF_ARRAY_BLKS;
      end
    end
    region_blocks = n[11:0];
  endfunction : region_blocks

  // -------------------------------------------------------------------
  // Pin synchronisation
  // -------------------------------------------------------------------
  qspif_pins_s pins_raw;
  qspif_pins_s pins;

  assign pins_raw = '{cs_n: cs_n_pin, sck: sck_pin, io: io_i};

  qspif_sync #(
    .W       (QSPIF_PINS_W),
    .RST_VAL (QSPIF_PINS_IDLE)
  ) u_sync (
    .clock  (clock),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .d      (pins_raw),
    .q      (pins)
  );

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  qspif_state_s st_reg;
  qspif_state_s st_next;

  logic        sel;
  logic        cs_fall;
  logic        quad_req;
  logic        refuse;
  logic        hold_ok;
  logic        active;
  logic        rise;
  logic        fall;
  logic        wp_n;
  logic [3:0]  cnt_sum;
  logic [7:0]  tx_cur;
  qspif_lane_e eff;

  always_comb
  begin
    st_next          = st_reg;
    st_next.rx_valid = 1'b0;
    st_next.tx_taken = 1'b0;
    st_next.sck_prev = pins.sck;
    st_next.cs_n_prev = pins.cs_n;

    sel      = !pins.cs_n;
    cs_fall  = st_reg.cs_n_prev && !pins.cs_n;
    quad_req = sel && (lane_mode == QSPIF_QUAD);
    refuse   = quad_req && protect_enable;
    eff      = refuse ? QSPIF_SINGLE : lane_mode;
    hold_ok  = sel && !st_reg.quad_act && !quad_req;
    cnt_sum  = 4'h0;
    tx_cur   = st_reg.tx_sh;

    if (cs_fall)
    begin
      st_next.armed = 1'b1;
      st_next.mode3 = pins.sck;
    end

    // latch quad use for the frame
    if (quad_req && !refuse)
    begin
      st_next.quad_act = 1'b1;
    end

    // pause follows pin only while clock is low
    if (hold_ok && !pins.sck)
    begin
      st_next.paused = !pins.io[QSPIF_IO3];
    end

    active = sel && st_reg.armed && !st_reg.paused && !refuse;
    rise   = active && pins.sck && !st_reg.sck_prev && !drive_out;
    fall   = active && !pins.sck && st_reg.sck_prev && drive_out;

    if (rise)
    begin
      cnt_sum          = {1'b0, st_reg.bit_cnt} + {1'b0, lane_step(eff)};
      st_next.rx_sh    = shift_in(st_reg.rx_sh, pins.io, eff);
      st_next.bit_cnt  = cnt_sum[2:0];
      if (cnt_sum[3])
      begin
        st_next.rx_data  = shift_in(st_reg.rx_sh, pins.io, eff);
        st_next.rx_valid = 1'b1;
      end
    end

    if (fall)
    begin
      if (st_reg.bit_cnt == 3'h0)
      begin
        tx_cur           = tx_data;
        st_next.tx_taken = 1'b1;
      end
      cnt_sum         = {1'b0, st_reg.bit_cnt} + {1'b0, lane_step(eff)};
      st_next.io_o    = lane_out(tx_cur, eff);
      st_next.tx_sh   = tx_cur << lane_step(eff);
      st_next.bit_cnt = cnt_sum[2:0];
    end

    if (active && drive_out)
    begin
      st_next.io_oe = lane_oe(eff);
    end
    else
    begin
      st_next.io_oe = 4'h0;
    end

    // Write-protect pin level, frozen while it carries quad data
    if (st_reg.quad_act || quad_req)
    begin
      wp_n = st_reg.wp_n_held;
    end
    else
    begin
      wp_n = pins.io[QSPIF_IO2];
      st_next.wp_n_held = wp_n;
    end

    st_next.array_write_ok = !(protect_enable && !wp_n);
    st_next.protreg_write_ok =
      !(!wp_n && (protect_enable ||
                  status_protect_field[QSPIF_SRP_HW_BIT]));
    st_next.protect_blocks = region_blocks(block_protect_field);
    st_next.quad_refused   = refuse;

    // frame state cleared on deselect
    if (!sel)
    begin
      st_next.paused   = 1'b0;
      st_next.quad_act = 1'b0;
      st_next.bit_cnt  = 3'h0;
      st_next.io_oe    = 4'h0;
    end
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_reg                  <= '0;
      st_reg.sck_prev         <= 1'b1;
      st_reg.cs_n_prev        <= 1'b1;
      st_reg.wp_n_held        <= 1'b1;
      st_reg.array_write_ok   <= 1'b1;
      st_reg.protreg_write_ok <= 1'b1;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign io_o             = st_reg.io_o;
  assign io_oe            = st_reg.io_oe;
  assign tx_taken         = st_reg.tx_taken;
  assign rx_data          = st_reg.rx_data;
  assign rx_valid         = st_reg.rx_valid;
  assign selected         = !st_reg.cs_n_prev;
  assign armed            = st_reg.armed;
  assign paused           = st_reg.paused;
  assign mode3            = st_reg.mode3;
  assign quad_refused     = st_reg.quad_refused;
  assign array_write_ok   = st_reg.array_write_ok;
  assign protreg_write_ok = st_reg.protreg_write_ok;
  assign protect_blocks   = st_reg.protect_blocks;

endmodule : qspif_pin_if

// ==== qspif_pin_if_bench.sv ====
// Self-checking bench of the pin interface with a host model.
// Assumes the checker is bound in through its own file.
module qspif_pin_if_bench
  import qspif_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock, rst_n = 1'b0, clk_en = 1'b1, drive_out = 1'b0;
  qspif_lane_e lane_mode = QSPIF_SINGLE;
  logic [7:0]  tx_data = 8'h00, rx_data;
  logic        protect_enable = 1'b0;
  logic [3:0]  block_protect_field = 4'h0, io_o, io_oe, flt = 4'h5;
  logic [1:0]  status_protect_field = 2'h0;
  logic        tx_taken, rx_valid, selected, armed, paused, mode3;
  logic        quad_refused, array_write_ok, protreg_write_ok;
  logic [11:0] protect_blocks;
  wire  [3:0]  h_o, h_oe, io_i;
  wire         cs_n_pin, sck_pin;
  int          err_total = 0, samples_checked = 0, rx_cnt = 0, n;
  int          tx_cnt = 0;

  // Line levels from all drivers, float toggles
  assign io_i = (io_oe & io_o) | (~io_oe & h_oe & h_o) | (~io_oe & ~h_oe & flt);
  always @(posedge clock) flt <= ~flt;
  always @(posedge clock) if (rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
  always @(posedge clock) if (tx_taken === 1'b1) tx_cnt <= tx_cnt + 1;

  qspif_pin_if i_dut (.clock, .rst_n, .clk_en, .cs_n_pin, .sck_pin, .io_i,
    .io_o, .io_oe, .lane_mode, .drive_out, .tx_data, .tx_taken, .rx_data,
    .rx_valid, .protect_enable, .block_protect_field, .status_protect_field,
    .selected, .armed, .paused, .mode3, .quad_refused, .array_write_ok,
    .protreg_write_ok, .protect_blocks);
  qspif_host i_host (.cs_n(cs_n_pin), .sck(sck_pin), .h_o, .h_oe, .io(io_i));

  // Clock at 40 MHz
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // One write byte then one read byte
  task automatic run_byte(input qspif_lane_e lm, input logic idle,
                          input logic [7:0] wr, input logic [7:0] rd);
    int         lanes;
    logic [7:0] got;
    lanes = lm == QSPIF_QUAD ? 4 : lm == QSPIF_DUAL ? 2 : 1;
    lane_mode = lm;
    i_host.sel(idle);
    n = rx_cnt;
    check("clock mode", 12'(mode3), 12'(idle));
    check("selected", 12'(selected), 12'h001);
    i_host.put(lanes, 8 / lanes, wr);
    repeat (4) @(negedge clock);
    check("rx count", 12'(rx_cnt - n), 12'h001);
    check("rx data", 12'(rx_data), 12'(wr));
    n = tx_cnt;
    drive_out = 1'b1;
    tx_data = rd;
    i_host.get(lanes, got);
    check("tx data", 12'(got), 12'(rd));
    check("tx count", 12'(tx_cnt - n), 12'h001);
    check("no pause", 12'(paused), 12'h000);
    // Drive phase left on so only the deselect can float the lines
    i_host.unsel();
    check("float", 12'(io_oe), 12'h000);
    check("deselected", 12'(selected), 12'h000);
    drive_out = 1'b0;
    lane_mode = QSPIF_SINGLE;
    $display("test byte %h done", wr);
  endtask : run_byte

  // Watchdog
  initial
  begin
    #300000;
    err_total++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(negedge clock);
    check("reset oe", 12'(io_oe), 12'h000);
    check("reset flags", 12'({armed, paused, selected, array_write_ok,
          protreg_write_ok}), 12'h003);
    check("reset blocks", protect_blocks, 12'h000);
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
    check("armed early", 12'(armed), 12'h000);
    run_byte(QSPIF_SINGLE, 1'b0, 8'h3c, 8'hc6);
    run_byte(QSPIF_DUAL, 1'b1, 8'h96, 8'h2d);
    run_byte(QSPIF_QUAD, 1'b0, 8'h5a, 8'he1);
    // Pause in mid-byte, clocks ignored
    i_host.sel(1'b0);
    i_host.put(1, 4, 8'ha5);
    i_host.lines(4'h4, 4'hd);
    repeat (8) @(negedge clock);
    check("paused", 12'(paused), 12'h001);
    i_host.put(1, 2, 8'hff);
    i_host.lines(4'hc, 4'hd);
    repeat (8) @(negedge clock);
    check("resumed", 12'(paused), 12'h000);
    i_host.put(1, 4, 8'h50);
    repeat (4) @(negedge clock);
    check("pause data", 12'(rx_data), 12'h0a5);
    i_host.unsel();
    $display("test pause done");
    // Quad refused with protect enabled
    protect_enable = 1'b1;
    lane_mode = QSPIF_QUAD;
    i_host.sel(1'b0);
    n = rx_cnt;
    i_host.put(4, 2, 8'h77);
    repeat (4) @(negedge clock);
    check("refused", 12'(quad_refused), 12'h001);
    check("refused rx", 12'(rx_cnt - n), 12'h000);
    i_host.unsel();
    lane_mode = QSPIF_SINGLE;
    $display("test refuse done");
    // Write protect modes
    i_host.lines(4'h8, 4'hc);
    repeat (8) @(negedge clock);
    check("hw array", 12'(array_write_ok), 12'h000);
    check("hw reg", 12'(protreg_write_ok), 12'h000);
    protect_enable = 1'b0;
    status_protect_field = 2'h1;
    repeat (8) @(negedge clock);
    check("sw array", 12'(array_write_ok), 12'h001);
    check("sw reg", 12'(protreg_write_ok), 12'h000);
    status_protect_field = 2'h0;
    repeat (8) @(negedge clock);
    check("sw reg free", 12'(protreg_write_ok), 12'h001);
    i_host.lines(4'hc, 4'hc);
    $display("test protect done");
    // Region size for every field value
    for (int f = 0; f < 16; f++)
    begin
      block_protect_field = 4'(f);
      repeat (4) @(negedge clock);
      check("blocks", protect_blocks,
            12'(f == 0 ? 0 : f > 9 ? 2048 : 4 << (f - 1)));
    end
    $display("test region done");
    tally_and_finish();
  end
endmodule : qspif_pin_if_bench

// ==== qspif_pin_if_chk.sv ====
// Port checker for the flash pin interface.
// Assumes the bind at the foot attaches it to each instance.
module qspif_pin_if_chk
  import qspif_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [3:0]  io_i,
  input wire logic [3:0]  io_oe,
  input wire qspif_lane_e lane_mode,
  input wire logic        rx_valid,
  input wire logic        tx_taken,
  input wire logic        protect_enable,
  input wire logic [3:0]  block_protect_field,
  input wire logic        selected,
  input wire logic        armed,
  input wire logic        paused,
  input wire logic        quad_refused,
  input wire logic        array_write_ok,
  input wire logic        protreg_write_ok,
  input wire logic [11:0] protect_blocks
);
  logic [11:0] exp_blocks;

  // Expected protected block count
  always_comb
  begin
    exp_blocks = 12'h000;
    if (block_protect_field > 4'h9)
      exp_blocks = 12'h800;
    else if (block_protect_field != 4'h0)
      exp_blocks = 12'h004 << (block_protect_field - 4'h1);
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ----------
  // Assertions
  // ----------
  // deselect floats lines
  desel_float_a : assert property (
    !selected [*3] |-> io_oe == 4'h0) else $error("drive when deselected");
  unarmed_quiet_a : assert property (
    !armed |-> !rx_valid && !tx_taken && io_oe == 4'h0)
    else $error("activity before arming");
  pause_float_a : assert property (
    paused [*2] |-> io_oe == 4'h0 && !rx_valid) else $error("active in pause");
  quad_refuse_a : assert property (
    quad_refused [*2] |-> io_oe == 4'h0 && !rx_valid)
    else $error("refused quad still active");
  single_lane_a : assert property (
    io_oe != 4'h0 && lane_mode == QSPIF_SINGLE &&
    $past(lane_mode) == QSPIF_SINGLE |-> io_oe == 4'h2)
    else $error("single mode drives wrong lines");
  hw_protect_a : assert property (
    (protect_enable && !io_i[2] && lane_mode == QSPIF_SINGLE) [*6]
    |-> !array_write_ok && !protreg_write_ok) else $error("write allowed");
  sw_protect_a : assert property (
    !protect_enable [*4] |-> array_write_ok) else $error("array blocked");
  region_size_a : assert property (
    $stable(block_protect_field) [*3] |-> protect_blocks == exp_blocks)
    else $error("wrong protected block count");
  quad_nopause_a : assert property (
    selected && lane_mode == QSPIF_QUAD && !paused |=> !paused)
    else $error("pause during quad");

  rx_seen_c : cover property (rx_valid);
  pause_seen_c : cover property (paused);
  refuse_seen_c : cover property (quad_refused);
endmodule : qspif_pin_if_chk

bind qspif_pin_if qspif_pin_if_chk i_chk (.clock, .rst_n, .io_i, .io_oe,
  .lane_mode, .rx_valid, .tx_taken, .protect_enable, .block_protect_field,
  .selected, .armed, .paused, .quad_refused, .array_write_ok,
  .protreg_write_ok, .protect_blocks);

// ==== qspif_pkg.sv ====
// Shared constants and types for the serial flash pin interface.
// Assumes every user of it imports the whole package.
package qspif_pkg;

  // -------------------------------------------------------------------
  // Widths and pin positions
  // -------------------------------------------------------------------
  localparam int         QSPIF_LANES     = 4;
  localparam int         QSPIF_BYTE_W    = 8;
  localparam int         QSPIF_IO0       = 0;
  localparam int         QSPIF_IO1       = 1;
  localparam int         QSPIF_IO2       = 2;
  localparam int         QSPIF_IO3       = 3;
  localparam int         QSPIF_PINS_W    = 6;
  localparam logic [5:0] QSPIF_PINS_IDLE = 6'h3f;

  // -------------------------------------------------------------------
  // Protection region
  // -------------------------------------------------------------------
  localparam int         QSPIF_BLK_W          = 12;
  localparam int         QSPIF_MIN_PROT_BLKS  = 4;
  localparam int         QSPIF_ARRAY_BLKS     = 2048;
  localparam int         QSPIF_SRP_HW_BIT     = 0;

  // -------------------------------------------------------------------
  // Lane modes and carriers
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    QSPIF_SINGLE,
    QSPIF_DUAL,
    QSPIF_QUAD
  } qspif_lane_e;

  // Raw pin levels, synchronised as one group
  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } qspif_pins_s;

  // Whole state of the pin interface
  typedef struct packed {
    logic                 sck_prev;
    logic                 cs_n_prev;
    logic                 armed;
    logic                 paused;
    logic                 quad_act;
    logic                 mode3;
    logic                 wp_n_held;
    logic [2:0]           bit_cnt;
    logic [7:0]           rx_sh;
    logic [7:0]           rx_data;
    logic                 rx_valid;
    logic [7:0]           tx_sh;
    logic                 tx_taken;
    logic                 quad_refused;
    logic                 array_write_ok;
    logic                 protreg_write_ok;
    logic [11:0]          protect_blocks;
    logic [3:0]           io_o;
    logic [3:0]           io_oe;
  } qspif_state_s;

endpackage : qspif_pkg

// ==== qspif_sync.sv ====
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clock.
module qspif_sync
  import qspif_pkg::*;
#(
  parameter int                W        = QSPIF_PINS_W,
  parameter logic [W-1:0]      RST_VAL  = QSPIF_PINS_IDLE
)(
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  input  wire logic [W-1:0]    d,
  output logic      [W-1:0]    q
);

  // -------------------------------------------------------------------
  // Elaboration check
  // -------------------------------------------------------------------
  if (W < 1)
  begin : g_chk
    $error("qspif_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } qspif_sync_s;

  qspif_sync_s st_reg;
  qspif_sync_s st_next;

  // First stage feeds only the second
  always_comb
  begin
    st_next        = st_reg;
    st_next.meta   = d;
    st_next.stable = st_reg.meta;
  end

  // State register with enable
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_reg <= {RST_VAL, RST_VAL};
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.stable;

endmodule : qspif_sync
